// ==== bench/etc_capture_checker.sv ====
// assertions on the ports of the event time capture unit
`timescale 1ns/10ps
module etc_capture_checker (
   // clock and reset
   input wire clk,
   input wire rstn,
   // pins and read port
   input wire [3:0] trigPin,
   input wire entryTake,
   input wire entryValid_q,
   input wire [3:0] entryPins_q,
   input wire [15:0] entryTag_q,
   // status
   input wire [15:0] tagTimer_q,
   input wire fifoEmpty_q,
   input wire overflow_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // timer steps by one, or by two on a skip
   a_timer_step: assert property ($changed(tagTimer_q) |->
      16'(tagTimer_q - $past(tagTimer_q)) inside {16'h0001, 16'h0002})
      else $error("timer step size wrong");
   a_timer_hold: assert property ($changed(tagTimer_q) |=>
      $stable(tagTimer_q)[*7]) else $error("timer stepped early");
   a_skip_due: assert property ($changed(tagTimer_q) |-> ##[0:72]
      (16'(tagTimer_q - $past(tagTimer_q)) == 16'h0002))
      else $error("no skipped tag within nine counts");
   // holding register fills first, fifo after it
   a_hold_first: assert property ($rose(entryValid_q) &&
      !$past(entryTake, 2) |-> fifoEmpty_q)
      else $error("holding loaded with fifo busy");
   a_fifo_second: assert property ($fell(fifoEmpty_q) |->
      entryValid_q) else $error("fifo filled before holding");
   a_mask_set: assert property (entryValid_q |->
      entryPins_q != 4'h0) else $error("entry without pin change");
   a_tag_fresh: assert property ($rose(entryValid_q) |->
      16'(tagTimer_q - entryTag_q) <= 16'h0002)
      else $error("entry tag not the current timer");
   a_tag_rise: assert property (entryTake && entryValid_q &&
      !fifoEmpty_q && !$past(entryTake) |=> entryValid_q &&
      entryTag_q > $past(entryTag_q)) else $error("next tag not later");
   // main scenarios
   cover property ($rose(overflow_q));
   cover property ($fell(fifoEmpty_q));
   cover property (entryTake && entryValid_q && !fifoEmpty_q);
endmodule // etc_capture_checker

bind etc_capture etc_capture_checker i_chk (.clk(clk), .rstn(rstn),
   .trigPin(trigPin), .entryTake(entryTake), .entryValid_q(entryValid_q),
   .entryPins_q(entryPins_q), .entryTag_q(entryTag_q),
   .tagTimer_q(tagTimer_q), .fifoEmpty_q(fifoEmpty_q),
   .overflow_q(overflow_q));

// ==== bench/etc_pin_model.sv ====
// external event sources driving the trigger pins
`timescale 1ns/10ps
module etc_pin_model (
   // clock
   input wire clk,
   // trigger pins toward the unit
   output logic [3:0] trigPin
);
   initial trigPin = 4'h0;
   // flip masked pins at an edge, then wait gap cycles
   task automatic flip(input logic [3:0] mask, input int gap);
      @(posedge clk);
      trigPin <= trigPin ^ mask;
      repeat (gap) @(posedge clk);
   endtask
endmodule // etc_pin_model

// ==== bench/tb.sv ====
// self-checking bench for the event time capture unit
`timescale 1ns/10ps
module tb;
   logic clk, rstn, entryTake, entryValid_q, fifoEmpty_q, overflow_q;
   logic [3:0] trigPin, entryPins_q;
   logic [15:0] entryTag_q, tagTimer_q, lastTag;
   int fails = 0;
   int comparisons = 0;
   etc_capture i_dut (.clk(clk), .rstn(rstn), .trigPin(trigPin),
      .entryTake(entryTake), .entryValid_q(entryValid_q),
      .entryPins_q(entryPins_q), .entryTag_q(entryTag_q),
      .tagTimer_q(tagTimer_q), .fifoEmpty_q(fifoEmpty_q),
      .overflow_q(overflow_q));
   etc_pin_model i_pin (.clk(clk), .trigPin(trigPin));
   // clock at 50 MHz
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // compare a mask or tag value
   task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // compare a flag
   task automatic chkFlag(input logic got, input logic exp);
      chkVal({15'h0000, got}, {15'h0000, exp});
   endtask
   // consume the holding entry and look at the next one
   task automatic take();
      @(posedge clk);
      entryTake <= 1'b1;
      @(posedge clk);
      entryTake <= 1'b0;
      @(negedge clk);
   endtask
   // nine timer steps hold exactly one skip
   task automatic testTimer();
      @(negedge clk);
      lastTag = tagTimer_q;
      repeat (72) @(negedge clk);
      chkVal(tagTimer_q, lastTag + 16'h000A);
   endtask
   // lone event, coincident pins, then a close second event
   task automatic testPair();
      i_pin.flip(4'h1, 16);
      @(negedge clk);
      chkFlag(entryValid_q, 1'b1);
      chkFlag(fifoEmpty_q, 1'b1);
      lastTag = entryTag_q;
      i_pin.flip(4'h6, 8);
      i_pin.flip(4'h8, 16);
      take();
      chkVal(entryPins_q, 4'h6);
      chkFlag(entryTag_q > lastTag, 1'b1);
      lastTag = entryTag_q;
      take();
      chkVal(entryPins_q, 4'h8);
      chkFlag(entryTag_q > lastTag, 1'b1);
      take();
      chkFlag(entryValid_q, 1'b0);
   endtask
   // fill holding and fifo until refused, then drain in order
   task automatic testFill();
      for (int i = 0; i < 17; i++) i_pin.flip(4'h1, 16);
      chkFlag(overflow_q, 1'b0);
      i_pin.flip(4'h1, 16);
      chkFlag(overflow_q, 1'b1);
      lastTag = 16'h0000;
      for (int i = 0; i < 17; i++) begin
         chkVal(entryPins_q, 4'h1);
         chkFlag(entryTag_q > lastTag, 1'b1);
         lastTag = entryTag_q;
         take();
      end
      chkFlag(entryValid_q, 1'b0);
      @(negedge clk);
      chkFlag(fifoEmpty_q, 1'b1);
   endtask
   // a one-state pulse on a pin never reaches a sample
   task automatic testGlitch();
      i_pin.flip(4'h4, 0);
      i_pin.flip(4'h4, 24);
      @(negedge clk);
      chkFlag(entryValid_q, 1'b0);
      chkFlag(fifoEmpty_q, 1'b1);
   endtask
   // nine events nine states apart land in nine samples in a row
   task automatic testSkip();
      logic [15:0] firstTag;
      logic [15:0] gapTag;
      logic [15:0] widest;
      widest = 16'h0000;
      for (int i = 0; i < 9; i++) i_pin.flip(4'h1 << (i % 2), 8);
      repeat (16) @(posedge clk);
      @(negedge clk);
      firstTag = entryTag_q;
      lastTag = entryTag_q;
      for (int i = 0; i < 8; i++) begin
         take();
         chkVal(entryPins_q, 4'h1 << ((i + 1) % 2));
         gapTag = entryTag_q - lastTag;
         chkFlag(gapTag >= 16'h0001, 1'b1);
         if (gapTag > widest) widest = gapTag;
         lastTag = entryTag_q;
      end
      chkVal(lastTag - firstTag, 16'h000A);
      chkFlag(widest >= 16'h0002, 1'b1);
      take();
      chkFlag(entryValid_q, 1'b0);
   endtask
   // print the verdict and stop
   task automatic finish_test();
      if (fails == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // reset, then the scenarios
   initial begin
      rstn = 1'b0;
      entryTake = 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      testTimer();
      testPair();
      testFill();
      testGlitch();
      testSkip();
      finish_test();
   end
   // cut a hang short
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end
endmodule // tb

// ==== core/etc_capture.v ====
// event time capture unit: pin sampling, tag timer, holding register
`timescale 1ns/10ps
`include "etc_map.vh"

module etc_capture #(
   parameter PINS = `ETC_PIN_COUNT,
   parameter TAG_W = `ETC_TAG_WIDTH,
   parameter DEPTH = `ETC_FIFO_DEPTH,
   parameter AW = 4
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // trigger pins from outside
   input wire [PINS-1:0] trigPin,
   // entry read port
   input wire entryTake,
   output reg entryValid_q,
   output reg [PINS-1:0] entryPins_q,
   output reg [TAG_W-1:0] entryTag_q,
   // status
   output reg [TAG_W-1:0] tagTimer_q,
   output reg fifoEmpty_q,
   output reg overflow_q
);

   localparam ENTRY_W = PINS + TAG_W;
   // last count of each divider, cut to the 4-bit counters on purpose
   localparam TIMER_END = `ETC_TIMER_STATES - 1;
   localparam SAMPLE_END = `ETC_SAMPLE_STATES - 1;
   localparam SKIP_END = `ETC_SKIP_COUNTS - 1;
   localparam [3:0] TIMER_LAST = TIMER_END[3:0];
   localparam [3:0] SAMPLE_LAST = SAMPLE_END[3:0];
   localparam [3:0] SKIP_LAST = SKIP_END[3:0];

   // wrapping step counter used by all three dividers
   function [3:0] stepWrap;
      input [3:0] value;
      input [3:0] last;
      begin
         stepWrap = (value == last) ? 4'h0 : value + 4'h1;
      end
   endfunction

   // --------------------------------------------------------------
   // pin synchroniser
   // --------------------------------------------------------------
   reg [PINS-1:0] sync1_q;
   reg [PINS-1:0] sync2_q;
   reg [PINS-1:0] sync3_q;
   reg [PINS-1:0] stable_q;
   reg [PINS-1:0] stable_d;
   integer i;

   // three flops; a bit counts once the second and third agree
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync1_q <= `ETC_PINS_RESET;
         sync2_q <= `ETC_PINS_RESET;
         sync3_q <= `ETC_PINS_RESET;
         stable_q <= `ETC_PINS_RESET;
      end else begin
         sync1_q <= trigPin;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         stable_q <= stable_d;
      end
   end

   // per-bit agreement filter
   always @* begin
      stable_d = stable_q;
      for (i = 0; i < PINS; i = i + 1) begin
         if (sync2_q[i] == sync3_q[i]) begin
            stable_d[i] = sync3_q[i];
         end
      end
   end

   // --------------------------------------------------------------
   // tag timer
   // --------------------------------------------------------------
   reg [3:0] prescale_q;
   reg [3:0] skipCnt_q;
   wire timerStep;
   wire skipStep;

   assign timerStep = (prescale_q == TIMER_LAST);
   assign skipStep = timerStep & (skipCnt_q == SKIP_LAST);

   // advance every eight states, jump by two once per nine counts
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prescale_q <= 4'h0;
         skipCnt_q <= 4'h0;
         tagTimer_q <= `ETC_TAG_RESET;
      end else begin
         prescale_q <= stepWrap(prescale_q, TIMER_LAST);
         if (timerStep) begin
            skipCnt_q <= stepWrap(skipCnt_q, SKIP_LAST);
            if (skipStep) begin
               tagTimer_q <= tagTimer_q + {{(TAG_W-2){1'b0}}, 2'h2};
            end else begin
               tagTimer_q <= tagTimer_q + {{(TAG_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // --------------------------------------------------------------
   // input sampling
   // --------------------------------------------------------------
   reg [3:0] sampleCnt_q;
   reg [PINS-1:0] lastSeen_q;
   wire sampleNow;
   wire [PINS-1:0] changed;
   wire newEvent;

   assign sampleNow = (sampleCnt_q == SAMPLE_LAST);
   // all pins that changed since the last sample share one entry
   assign changed = stable_q ^ lastSeen_q;
   assign newEvent = sampleNow & (|changed);

   // look at the pins only once per nine states
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sampleCnt_q <= 4'h0;
         lastSeen_q <= `ETC_PINS_RESET;
      end else begin
         sampleCnt_q <= stepWrap(sampleCnt_q, SAMPLE_LAST);
         if (sampleNow) begin
            lastSeen_q <= stable_q;
         end
      end
   end

   // --------------------------------------------------------------
   // fifo behind the holding register
   // --------------------------------------------------------------
   wire fifoInValid;
   wire fifoInReady;
   wire fifoOutValid;
   wire fifoOutReady;
   wire [ENTRY_W-1:0] fifoOutData;
   wire fifoIsEmpty;
   wire holdFree;
   wire toHold;

   // holding register is free when empty or being read this cycle
   assign holdFree = ~entryValid_q | entryTake;
   // straight to holding only while both stages are empty
   assign toHold = newEvent & ~entryValid_q & fifoIsEmpty;
   assign fifoInValid = newEvent & ~toHold;
   assign fifoOutReady = holdFree;

   etc_fifo #(
      .WIDTH(ENTRY_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) entryFifo (
      .clk(clk),
      .rstn(rstn),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData({changed, tagTimer_q}),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData),
      .isEmpty(fifoIsEmpty)
   );

   // --------------------------------------------------------------
   // holding register and status
   // --------------------------------------------------------------
   // tag taken from the timer at the sample, so a following sample
   // is at least one count later and two across a skipped value
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         entryValid_q <= 1'b0;
         entryPins_q <= `ETC_PINS_RESET;
         entryTag_q <= `ETC_TAG_RESET;
         fifoEmpty_q <= 1'b1;
         overflow_q <= 1'b0;
      end else begin
         if (toHold) begin
            entryValid_q <= 1'b1;
            entryPins_q <= changed;
            entryTag_q <= tagTimer_q;
         end else if (holdFree && fifoOutValid) begin
            entryValid_q <= 1'b1;
            entryPins_q <= fifoOutData[ENTRY_W-1:TAG_W];
            entryTag_q <= fifoOutData[TAG_W-1:0];
         end else if (entryTake) begin
            entryValid_q <= 1'b0;
         end
         fifoEmpty_q <= fifoIsEmpty;
         // a full fifo refuses the entry; flag it until reset
         if (fifoInValid && !fifoInReady) begin
            overflow_q <= 1'b1;
         end
      end
   end

endmodule // etc_capture

// ==== core/etc_fifo.v ====
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/10ps

module etc_fifo #(
   parameter WIDTH = 20,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // clock and reset
   input wire clk,
   input wire rstn,
   // filling side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // draining side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData,
   // fill level
   output wire isEmpty
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] count_q;
   wire doWrite;
   wire doRead;

   // --------------------------------------------------------------
   // flags
   // --------------------------------------------------------------
   // honest full and empty from the fill count
   assign inReady = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign isEmpty = ~outValid;
   assign outData = mem[rdPtr_q];
   assign doWrite = inValid & inReady;
   assign doRead = outValid & outReady;

   // storage array, no reset needed
   always @(posedge clk) begin
      if (doWrite) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // --------------------------------------------------------------
   // pointers
   // --------------------------------------------------------------
   // pointers wrap at the depth
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end else begin
         if (doWrite) begin
            wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ?
               {AW{1'b0}} : wrPtr_q + 1'b1;
         end
         if (doRead) begin
            rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ?
               {AW{1'b0}} : rdPtr_q + 1'b1;
         end
         if (doWrite && !doRead) begin
            count_q <= count_q + 1'b1;
         end else if (doRead && !doWrite) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule // etc_fifo

// ==== inc/etc_map.vh ====
// timing counts and field layout of the event time capture unit
`ifndef ETC_MAP_VH
`define ETC_MAP_VH

// state times per tag timer count
`define ETC_TIMER_STATES 8
// state times between two samples of the trigger pins
`define ETC_SAMPLE_STATES 9
// timer counts per skipped tag value
`define ETC_SKIP_COUNTS 9
// number of trigger pins
`define ETC_PIN_COUNT 4
// width of the tag timer
`define ETC_TAG_WIDTH 16
// entries held by the fifo behind the holding register
`define ETC_FIFO_DEPTH 16
// reset values
`define ETC_PINS_RESET 4'h0
`define ETC_TAG_RESET 16'h0000

`endif
